// [design/stn_pkg.sv]
package stn_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] red_table_off = 8'h00;
    localparam logic [7:0] green_table_off = 8'h04;
    localparam logic [7:0] blue_table_off = 8'h08;
    localparam logic [7:0] dp_half_off = 8'h0C;
    localparam logic [7:0] dp_four_sevenths_off = 8'h10;
    localparam logic [7:0] dp_three_fifths_off = 8'h14;
    localparam logic [7:0] dp_two_thirds_off = 8'h18;
    localparam logic [7:0] dp_five_sevenths_off = 8'h1C;
    localparam logic [7:0] dp_three_quarters_off = 8'h20;
    localparam logic [7:0] dp_four_fifths_off = 8'h24;
    localparam logic [7:0] dp_six_sevenths_off = 8'h28;
    localparam logic [7:0] control_off = 8'h2C;
    localparam logic [7:0] timing_off = 8'h30;
    localparam logic [7:0] status_off = 8'h34;

    // control register fields
    localparam int ctl_enable_bit = 0;
    localparam int ctl_self_refresh_bit = 1;
    localparam int ctl_bias_mode_bit = 2;
    localparam int ctl_idle_bit = 3;
    localparam int ctl_bias_lsb = 8;
    localparam int ctl_bias_w = 8;

    // timing register fields
    localparam int tim_clkdiv_lsb = 0;
    localparam int tim_clkdiv_w = 10;
    localparam int tim_hoz_lsb = 10;
    localparam int tim_hoz_w = 11;
    localparam int tim_line_lsb = 21;
    localparam int tim_line_w = 10;

    localparam logic [9:0] min_clkdiv = 10'h002;
    localparam logic [3:0] level_full = 4'hF;
    localparam logic [3:0] level_off = 4'h0;
    localparam logic [3:0] level_half = 4'h7;
    localparam int level_w = 4;
    localparam int pattern_count = 8;

    // pattern lengths per pattern family; stn_dither_bit maps each slot to one
    localparam int len_half = 16;
    localparam int len_sevenths = 28;
    localparam int len_fifths = 20;
    localparam int len_thirds = 12;
    localparam int len_quarters = 16;

    // reset values of the pattern and table registers
    localparam logic [31:0] half_reset = 32'h0000A5A5;
    localparam logic [31:0] two_thirds_reset = 32'h00000D6B;
    localparam logic [31:0] six_sevenths_reset = 32'h07FDFBFE;
    localparam logic [31:0] zero_word = 32'h00000000;

    localparam logic [3:0] line_pulse_len = 4'h4;

    typedef struct packed {
        logic enable;
        logic self_refresh;
        logic bias_per_lines;
        logic idle;
        logic [7:0] bias_lines;
        logic [9:0] clkdiv;
        logic [10:0] hoz_last;
        logic [9:0] line_last;
    } panel_cfg_t;

    typedef struct packed {
        logic shift_clk;
        logic [7:0] data;
        logic frame;
        logic line;
        logic bias;
    } panel_pins_t;
endpackage : stn_pkg

// [design/stn_dither_bit.sv]
`timescale 1ns/10ps
// one color component: level in, on/off bit out for this frame and position
module stn_dither_bit (
    input wire logic [3:0] level,
    input wire logic [6:0] frame_cnt,
    input wire logic [10:0] position,
    input wire logic [255:0] patterns,
    output logic pixel_bit
);
    logic [2:0] slot;
    logic invert;
    logic [4:0] plen;
    logic [31:0] word;
    logic [11:0] phase;
    logic [4:0] idx;
    logic pat_bit;

    // levels 8..14 map to slots 1..7; 1..3 reuse slots 7..5 and 4..6 slots 3..1, inverted
    always_comb begin
        invert = 1'b0;
        slot = 3'h0;
        if (level > stn_pkg::level_half) begin
            slot = 3'(level - stn_pkg::level_half);
        end else if (level != stn_pkg::level_half) begin
            slot = (level < 4'h4) ? 3'(4'h8 - level) : 3'(4'h7 - level);
            invert = 1'b1;
        end
    end

    always_comb begin
        unique case (slot)
            3'h0: plen = 5'(stn_pkg::len_half);
            3'h1, 3'h4, 3'h7: plen = 5'(stn_pkg::len_sevenths);
            3'h2, 3'h6: plen = 5'(stn_pkg::len_fifths);
            3'h3: plen = 5'(stn_pkg::len_thirds);
            default: plen = 5'(stn_pkg::len_quarters);
        endcase
    end

    // frame plus position, modulo pattern length, gives the phase
    assign word = patterns[slot*32 +: 32];
    assign phase = 12'(frame_cnt) + 12'(position);
    assign idx = 5'(phase % 12'(plen));
    assign pat_bit = word[plen - 5'h1 - idx];

    assign pixel_bit = (level == stn_pkg::level_full) ? 1'b1 :
                       (level == stn_pkg::level_off) ? 1'b0 : (pat_bit ^ invert);
endmodule : stn_dither_bit

// [design/stn_pixel_path.sv]
`timescale 1ns/10ps
// color split, table lookup and dithering of one 8-bit pixel
module stn_pixel_path (
    input wire logic [7:0] pixel,
    input wire logic [31:0] red_table,
    input wire logic [31:0] green_table,
    input wire logic [15:0] blue_table,
    input wire logic [255:0] patterns,
    input wire logic [6:0] frame_cnt,
    input wire logic [10:0] position,
    output logic [2:0] rgb_bits
);
    logic [2:0] red_index;
    logic [2:0] green_index;
    logic [1:0] blue_index;
    logic [11:0] levels;

    assign red_index = pixel[7:5];
    assign green_index = pixel[4:2];
    assign blue_index = pixel[1:0];
    assign levels[11:8] = red_table[red_index*4 +: 4];
    assign levels[7:4] = green_table[green_index*4 +: 4];
    assign levels[3:0] = blue_table[blue_index*4 +: 4];

    // each component sits at its own sub-position so neighbours differ in phase
    genvar c;
    generate
        for (c = 0; c < 3; c++) begin : g_comp
            stn_dither_bit u_bit (
                .level(levels[c*4 +: 4]),
                .frame_cnt(frame_cnt),
                .position(11'(position + 11'(2 - c))),
                .patterns(patterns),
                .pixel_bit(rgb_bits[c])
            );
        end
    endgenerate
endmodule : stn_pixel_path

// [design/stn_color_lut_frc_dither.sv]
`timescale 1ns/10ps
// Behaviour
// - pixel splits into red, green, blue indices
// - red index picks 4-bit red table field
// - green index picks 4-bit green table field
// - blue index picks 4-bit blue table field
// - looked-up levels pass through dither stage
// - level fifteen on, level zero off
// - middle levels take bit from patterns
// - levels seven to fourteen use duty patterns
// - low levels reuse high patterns inverted
// - eight pattern registers of documented widths
// - bit depends on frame and position
// - half pattern alternates neighbours and frames
// - self-refresh starts at the next line
// - self-refresh freezes clock, data; timing continues
// - idle mode only flags a display-only clocking request
// - shift data with clock, pulse line after
// - bias toggles per frame or lines
// - enable low stops output, clears input
module stn_color_lut_frc_dither (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pixel_in,
    input wire logic pixel_valid,
    output logic pixel_ready,
    output logic pixel_shift_clock,
    output logic [7:0] pixel_data_out,
    output logic frame_pulse,
    output logic line_pulse,
    output logic ac_bias_toggle,
    output logic display_only_idle_mode
);
    typedef enum logic [1:0] {
        st_off = 2'b00,
        st_shift = 2'b01,
        st_line = 2'b11,
        st_refresh = 2'b10
    } mode_t;

    logic [31:0] red_level_table_ff, green_level_table_ff;
    logic [15:0] blue_level_table_ff;
    logic [15:0] dither_half_pattern_ff, dither_three_quarters_pattern_ff;
    logic [27:0] dither_four_sevenths_pattern_ff, dither_five_sevenths_pattern_ff;
    logic [27:0] dither_six_sevenths_pattern_ff;
    logic [19:0] dither_three_fifths_pattern_ff, dither_four_fifths_pattern_ff;
    logic [11:0] dither_two_thirds_pattern_ff;
    logic [31:0] control_ff, timing_ff;
    stn_pkg::panel_cfg_t cfg;
    stn_pkg::panel_pins_t pins_ff, nxt_pins;
    mode_t mode_ff, nxt_mode;
    logic [9:0] div_ff;
    logic [10:0] col_ff;
    logic [9:0] row_ff;
    logic [6:0] frame_cnt_ff;
    logic [7:0] bias_cnt_ff;
    logic [3:0] pulse_ff;
    logic [2:0] phase_ff;
    logic [7:0] shift_ff, byte_out;
    logic refresh_arm_ff;
    logic [255:0] patterns;
    logic [2:0] rgb_bits;
    logic wr_en, rd_en;
    logic div_tick, line_end, frame_end, take_pixel, shifted_byte, col_step, bias_due;
    logic [31:0] rd_word;
    logic addr_hit;

    // patterns padded to one word each, slot order half, 4/7 .. 6/7
    assign patterns = {4'h0, dither_six_sevenths_pattern_ff, 12'h000, dither_four_fifths_pattern_ff,
                       16'h0000, dither_three_quarters_pattern_ff, 4'h0, dither_five_sevenths_pattern_ff,
                       20'h00000, dither_two_thirds_pattern_ff, 12'h000, dither_three_fifths_pattern_ff,
                       4'h0, dither_four_sevenths_pattern_ff, 16'h0000, dither_half_pattern_ff};

    assign cfg.enable = control_ff[stn_pkg::ctl_enable_bit];
    assign cfg.self_refresh = control_ff[stn_pkg::ctl_self_refresh_bit];
    assign cfg.bias_per_lines = control_ff[stn_pkg::ctl_bias_mode_bit];
    assign cfg.idle = control_ff[stn_pkg::ctl_idle_bit];
    assign cfg.bias_lines = control_ff[stn_pkg::ctl_bias_lsb +: stn_pkg::ctl_bias_w];
    assign cfg.clkdiv = timing_ff[stn_pkg::tim_clkdiv_lsb +: stn_pkg::tim_clkdiv_w];
    assign cfg.hoz_last = timing_ff[stn_pkg::tim_hoz_lsb +: stn_pkg::tim_hoz_w];
    assign cfg.line_last = timing_ff[stn_pkg::tim_line_lsb +: stn_pkg::tim_line_w];

    // apb decode, zero wait states
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~pwrite;
    assign pready = 1'b1;
    assign addr_hit = (paddr <= stn_pkg::status_off) && (paddr[1:0] == 2'b00);
    assign pslverr = psel & penable & ~addr_hit;
    assign rd_word =
        (paddr == stn_pkg::red_table_off) ? red_level_table_ff :
        (paddr == stn_pkg::green_table_off) ? green_level_table_ff :
        (paddr == stn_pkg::blue_table_off) ? {16'h0000, blue_level_table_ff} :
        (paddr == stn_pkg::dp_half_off) ? {16'h0000, dither_half_pattern_ff} :
        (paddr == stn_pkg::dp_four_sevenths_off) ? {4'h0, dither_four_sevenths_pattern_ff} :
        (paddr == stn_pkg::dp_three_fifths_off) ? {12'h000, dither_three_fifths_pattern_ff} :
        (paddr == stn_pkg::dp_two_thirds_off) ? {20'h00000, dither_two_thirds_pattern_ff} :
        (paddr == stn_pkg::dp_five_sevenths_off) ? {4'h0, dither_five_sevenths_pattern_ff} :
        (paddr == stn_pkg::dp_three_quarters_off) ? {16'h0000, dither_three_quarters_pattern_ff} :
        (paddr == stn_pkg::dp_four_fifths_off) ? {12'h000, dither_four_fifths_pattern_ff} :
        (paddr == stn_pkg::dp_six_sevenths_off) ? {4'h0, dither_six_sevenths_pattern_ff} :
        (paddr == stn_pkg::control_off) ? control_ff :
        (paddr == stn_pkg::timing_off) ? timing_ff :
        (paddr == stn_pkg::status_off) ? {13'h0000, frame_cnt_ff, row_ff, mode_ff} :
        stn_pkg::zero_word;

    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= stn_pkg::zero_word;
        end else if (rd_en & ~penable) begin
            prdata <= rd_word;
        end
    end

    // software-owned registers; recommended patterns preloaded where given
    always_ff @(posedge mclk) begin
        if (reset) begin
            red_level_table_ff <= stn_pkg::zero_word;
            green_level_table_ff <= stn_pkg::zero_word;
            blue_level_table_ff <= 16'h0000;
            dither_half_pattern_ff <= stn_pkg::half_reset[15:0];
            dither_four_sevenths_pattern_ff <= 28'h0000000;
            dither_three_fifths_pattern_ff <= 20'h00000;
            dither_two_thirds_pattern_ff <= stn_pkg::two_thirds_reset[11:0];
            dither_five_sevenths_pattern_ff <= 28'h0000000;
            dither_three_quarters_pattern_ff <= 16'h0000;
            dither_four_fifths_pattern_ff <= 20'h00000;
            dither_six_sevenths_pattern_ff <= stn_pkg::six_sevenths_reset[27:0];
            control_ff <= stn_pkg::zero_word;
            timing_ff <= stn_pkg::zero_word;
        end else if (wr_en) begin
            unique case (paddr)
                stn_pkg::red_table_off: red_level_table_ff <= pwdata;
                stn_pkg::green_table_off: green_level_table_ff <= pwdata;
                stn_pkg::blue_table_off: blue_level_table_ff <= pwdata[15:0];
                stn_pkg::dp_half_off: dither_half_pattern_ff <= pwdata[15:0];
                stn_pkg::dp_four_sevenths_off: dither_four_sevenths_pattern_ff <= pwdata[27:0];
                stn_pkg::dp_three_fifths_off: dither_three_fifths_pattern_ff <= pwdata[19:0];
                stn_pkg::dp_two_thirds_off: dither_two_thirds_pattern_ff <= pwdata[11:0];
                stn_pkg::dp_five_sevenths_off: dither_five_sevenths_pattern_ff <= pwdata[27:0];
                stn_pkg::dp_three_quarters_off: dither_three_quarters_pattern_ff <= pwdata[15:0];
                stn_pkg::dp_four_fifths_off: dither_four_fifths_pattern_ff <= pwdata[19:0];
                stn_pkg::dp_six_sevenths_off: dither_six_sevenths_pattern_ff <= pwdata[27:0];
                stn_pkg::control_off: control_ff <= pwdata;
                stn_pkg::timing_off: timing_ff <= pwdata;
                default: ;
            endcase
        end
    end

    stn_pixel_path u_path (
        .pixel(pixel_in),
        .red_table(red_level_table_ff),
        .green_table(green_level_table_ff),
        .blue_table(blue_level_table_ff),
        .patterns(patterns),
        .frame_cnt(frame_cnt_ff),
        .position(col_ff),
        .rgb_bits(rgb_bits)
    );

    // idle clocking is done by the power manager; this only flags the request
    assign display_only_idle_mode = cfg.idle & cfg.enable;

    // shift clock period is twice the divider, divider floored at its minimum
    assign div_tick = (div_ff == 10'h000);
    // refresh counts one idle column per divider tick so line, frame and bias keep going
    assign col_step = shifted_byte | ((mode_ff == st_refresh) & div_tick);
    assign line_end = (col_ff == cfg.hoz_last) & col_step;
    assign frame_end = (mode_ff == st_line) & (pulse_ff == 4'h1) & (row_ff == cfg.line_last);
    // three bits per pixel pile up; a byte leaves once eight are held
    assign shifted_byte = take_pixel & (phase_ff >= 3'h5);
    assign byte_out = 8'({shift_ff, rgb_bits} >> (phase_ff - 3'h5));
    assign bias_due = (9'(bias_cnt_ff) + 9'h001 >= 9'(cfg.bias_lines));
    assign take_pixel = (mode_ff == st_shift) & div_tick & pins_ff.shift_clk & pixel_valid;
    assign pixel_ready = take_pixel;

    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            st_off: if (cfg.enable & ~cfg.self_refresh) nxt_mode = st_shift;
            st_shift: if (line_end) nxt_mode = st_line;
            st_line: if (pulse_ff == 4'h1) nxt_mode = refresh_arm_ff ? st_refresh : st_shift;
            st_refresh: if (line_end) nxt_mode = st_line;
        endcase
        if (!cfg.enable) nxt_mode = st_off;
    end

    // pins: clock low and data held in refresh, timing signals keep running
    always_comb begin
        nxt_pins = pins_ff;
        if (mode_ff == st_off) begin
            nxt_pins = '0;
        end else if (mode_ff == st_refresh) begin
            nxt_pins.shift_clk = 1'b0;
        end else if (mode_ff == st_shift && div_tick && (pixel_valid || pins_ff.shift_clk)) begin
            nxt_pins.shift_clk = ~pins_ff.shift_clk;
            if (shifted_byte) nxt_pins.data = byte_out;
        end
        nxt_pins.line = (mode_ff == st_line);
        nxt_pins.frame = (mode_ff != st_off) && (row_ff == 10'h000);
        if (frame_end && !cfg.bias_per_lines) nxt_pins.bias = ~pins_ff.bias;
        if (line_end && cfg.bias_per_lines && bias_due) nxt_pins.bias = ~pins_ff.bias;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_ff <= st_off;
            pins_ff <= '0;
            refresh_arm_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            pins_ff <= nxt_pins;
            refresh_arm_ff <= cfg.self_refresh & cfg.enable;
        end
    end

    // counters: divider, column, row, frame, bias, pulse width, byte packing
    always_ff @(posedge mclk) begin
        if (reset || mode_ff == st_off) begin
            div_ff <= 10'h000;
            col_ff <= 11'h000;
            row_ff <= 10'h000;
            frame_cnt_ff <= 7'h00;
            bias_cnt_ff <= 8'h00;
            pulse_ff <= 4'h0;
            phase_ff <= 3'h0;
            shift_ff <= 8'h00;
        end else begin
            div_ff <= div_tick ? ((cfg.clkdiv < stn_pkg::min_clkdiv) ? stn_pkg::min_clkdiv : cfg.clkdiv) - 10'h001
                               : div_ff - 10'h001;
            if (take_pixel) begin
                shift_ff <= {shift_ff[4:0], rgb_bits};
                phase_ff <= (phase_ff >= 3'h5) ? phase_ff - 3'h5 : phase_ff + 3'h3;
            end
            if (col_step) col_ff <= line_end ? 11'h000 : col_ff + 11'h001;
            if (mode_ff != st_line && nxt_mode == st_line) pulse_ff <= stn_pkg::line_pulse_len;
            else if (pulse_ff != 4'h0) pulse_ff <= pulse_ff - 4'h1;
            if (mode_ff == st_line && pulse_ff == 4'h1) begin
                row_ff <= frame_end ? 10'h000 : row_ff + 10'h001;
                bias_cnt_ff <= bias_due ? 8'h00 : bias_cnt_ff + 8'h01;
                if (frame_end) frame_cnt_ff <= frame_cnt_ff + 7'h01;
            end
        end
    end

    assign pixel_shift_clock = pins_ff.shift_clk;
    assign pixel_data_out = pins_ff.data;
    assign frame_pulse = pins_ff.frame;
    assign line_pulse = pins_ff.line;
    assign ac_bias_toggle = pins_ff.bias;
endmodule : stn_color_lut_frc_dither

// [verification/stn_properties.sv]
`timescale 1ns/10ps
module stn_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pixel_valid,
    input wire logic pixel_ready,
    input wire logic pixel_shift_clock,
    input wire logic [7:0] pixel_data_out,
    input wire logic frame_pulse,
    input wire logic line_pulse,
    input wire logic ac_bias_toggle,
    input wire logic display_only_idle_mode
);
    default clocking cb @(posedge mclk);
    endclocking
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_unmapped;
        psel && penable && paddr > 8'h34;
    endsequence
    chk_pready_zero_wait: assert property (disable iff (reset) s_access |-> pready)
        else $error("pready low in access phase");
    chk_err_unmapped: assert property (disable iff (reset) s_unmapped |-> pslverr)
        else $error("unmapped access without error");
    chk_err_mapped: assert property (disable iff (reset)
        s_access ##0 (paddr <= 8'h34 && paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("error on mapped access");
    chk_err_idle: assert property (disable iff (reset) !(psel && penable) |-> !pslverr)
        else $error("error outside access phase");
    chk_rd_unmapped: assert property (disable iff (reset) s_unmapped ##0 !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_rdata_stands: assert property (disable iff (reset) s_access ##1 !psel |-> $stable(prdata))
        else $error("read data moved after access");
    chk_line_width: assert property (disable iff (reset)
        $rose(line_pulse) |-> line_pulse [*4] ##1 !line_pulse)
        else $error("line pulse width wrong");
    chk_pixel_one_shot: assert property (disable iff (reset)
        pixel_valid && pixel_ready |=> !pixel_ready)
        else $error("two pixels taken back to back");
    chk_reset_quiet: assert property (reset |=> !pixel_shift_clock && pixel_data_out == 8'h00
        && !line_pulse && !frame_pulse && !ac_bias_toggle && !display_only_idle_mode)
        else $error("panel pins active after reset");
endmodule : stn_properties

// [verification/stn_panel_model.sv]
`timescale 1ns/10ps
// passive row/column driver: latches a byte at every falling shift clock edge
module stn_panel_model (
    input wire logic mclk,
    input wire logic clear,
    input wire stn_pkg::panel_pins_t pins,
    output logic [7:0] and_all,
    output logic [7:0] or_all,
    output int lines,
    output int falls,
    output int flips
);
    stn_pkg::panel_pins_t prev_ff;
    // lines is never cleared so waiters can count relative to it
    always @(posedge mclk) begin
        prev_ff <= pins;
        if (pins.line && !prev_ff.line) begin
            lines <= lines + 1;
        end
        if (clear) begin
            and_all <= 8'hFF;
            or_all <= 8'h00;
            falls <= 0;
            flips <= 0;
        end else begin
            if (prev_ff.shift_clk && !pins.shift_clk) begin
                and_all <= and_all & pins.data;
                or_all <= or_all | pins.data;
                falls <= falls + 1;
            end
            if (pins.bias != prev_ff.bias) begin
                flips <= flips + 1;
            end
        end
    end
endmodule : stn_panel_model

// [verification/stn_color_lut_frc_dither_tb.sv]
`timescale 1ns/10ps
module stn_color_lut_frc_dither_tb;
    localparam logic [7:0] ctl = stn_pkg::control_off;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] pixel_in = 8'h00;
    logic pixel_valid = 1'b0;
    logic clr = 1'b1;
    logic pready, pslverr, pixel_ready, sclk, frame_pulse, line_pulse, bias, idle, ev;
    logic [7:0] pdata, and_all, or_all, a, o;
    logic [31:0] prdata, rv;
    int lines, falls, flips;
    int bad_count = 0;
    int total_checks = 0;
    stn_pkg::panel_pins_t pins;
    assign pins = {sclk, pdata, frame_pulse, line_pulse, bias};
    always #10 mclk = ~mclk;
    stn_color_lut_frc_dither DUT (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pixel_in(pixel_in),
        .pixel_valid(pixel_valid), .pixel_ready(pixel_ready), .pixel_shift_clock(sclk), .pixel_data_out(pdata),
        .frame_pulse(frame_pulse), .line_pulse(line_pulse), .ac_bias_toggle(bias), .display_only_idle_mode(idle));
    stn_panel_model panel (.mclk(mclk), .clear(clr), .pins(pins), .and_all(and_all), .or_all(or_all),
        .lines(lines), .falls(falls), .flips(flips));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // ends one idle cycle later so two calls never touch psel in one step
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask : wr
    task automatic wait_lines(input int n);
        int t0;
        int k;
        t0 = lines;
        k = 0;
        while (lines < t0 + n && k < 20000) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 20000) chk(32'h0, 32'h1);
    endtask : wait_lines
    task automatic clear_model;
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
    endtask : clear_model
    // two lines settle the pipeline after enable, the next two are judged
    task automatic measure(input logic [31:0] rt, input logic [31:0] gt, input logic [31:0] bt, input logic [7:0] px);
        wr(ctl, 32'h0);
        wr(stn_pkg::red_table_off, rt);
        wr(stn_pkg::green_table_off, gt);
        wr(stn_pkg::blue_table_off, bt);
        pixel_in <= px;
        wr(ctl, 32'h1);
        wait_lines(2);
        clear_model;
        wait_lines(2);
        a = and_all;
        o = or_all;
    endtask : measure
    task automatic level(input logic [3:0] l);
        measure({8{l}}, {8{l}}, {16'h0, {4{l}}}, 8'h00);
    endtask : level
    task automatic s_regs;
        int w[11] = '{32, 32, 16, 16, 28, 20, 12, 28, 16, 20, 28};
        logic [31:0] r0;
        for (int k = 0; k < 11; k++) begin
            r0 = k == 3 ? stn_pkg::half_reset : k == 6 ? stn_pkg::two_thirds_reset :
                k == 10 ? stn_pkg::six_sevenths_reset : 32'h0;
            apb(1'b0, 8'(4 * k), 32'h0);
            chk(rv, r0);
            wr(8'(4 * k), 32'hFFFFFFFF);
            apb(1'b0, 8'(4 * k), 32'h0);
            chk(rv, w[k] == 32 ? 32'hFFFFFFFF : (32'h1 << w[k]) - 32'h1);
        end
        apb(1'b0, 8'h38, 32'h0);
        chk({31'h0, ev}, 32'h1);
        chk(rv, 32'h0);
    endtask : s_regs
    task automatic s_levels;
        level(4'h0);
        chk({24'h0, o}, 32'h0);
        for (int k = 0; k < 8; k++) begin
            for (int j = 0; j < 8; j++) wr(8'(stn_pkg::dp_half_off + 4 * j), j == k ? 32'hFFFFFFFF : 32'h0);
            level(4'(7 + k));
            chk({24'h0, a}, 32'hFF);
            // the 5/7 slot has no low-level partner
            if (k > 0 && k != 4) begin
                level(4'(k > 4 ? 8 - k : 7 - k));
                chk({24'h0, o}, 32'h0);
            end
        end
        level(4'hF);
        chk({24'h0, a}, 32'hFF);
    endtask : s_levels
    task automatic s_lut;
        for (int n = 0; n < 8; n++) begin
            measure(32'hF << (4 * n), 32'hFFFFFFFF, 32'hFFFF, {3'(n), 5'h1F});
            chk({24'h0, a}, 32'hFF);
            measure(32'hF << (4 * n), 32'hFFFFFFFF, 32'hFFFF, {3'(n + 1), 5'h1F});
            chk({31'h0, a == 8'hFF}, 32'h0);
        end
        measure(32'hFFFFFFFF, 32'h00000F00, 32'hFFFF, 8'hEB);
        chk({24'h0, a}, 32'hFF);
        measure(32'hFFFFFFFF, 32'h00000F00, 32'hFFFF, 8'hEF);
        chk({31'h0, a == 8'hFF}, 32'h0);
        measure(32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00F0, 8'hFD);
        chk({24'h0, a}, 32'hFF);
        measure(32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00F0, 8'hFE);
        chk({31'h0, a == 8'hFF}, 32'h0);
    endtask : s_lut
    task automatic s_modes;
        logic [7:0] d;
        wr(stn_pkg::dp_half_off, stn_pkg::half_reset);
        level(4'h7);
        chk({31'h0, a != 8'hFF && o != 8'h00}, 32'h1);
        clear_model;
        wait_lines(8);
        chk({31'h0, flips >= 3 && flips <= 5}, 32'h1);
        wr(ctl, 32'h00000105);
        clear_model;
        wait_lines(8);
        chk({31'h0, flips >= 7 && flips <= 9}, 32'h1);
        wr(ctl, 32'h3);
        wait_lines(2);
        clear_model;
        d = pdata;
        wait_lines(4);
        chk(32'(falls), 32'h0);
        chk({24'h0, pdata}, {24'h0, d});
        chk({31'h0, flips > 0}, 32'h1);
        wr(ctl, 32'h6);
        clear_model;
        repeat (200) @(posedge mclk);
        chk(32'(falls), 32'h0);
        wr(ctl, 32'h4);
        wr(ctl, 32'h5);
        clear_model;
        wait_lines(2);
        chk({31'h0, falls > 0}, 32'h1);
        wr(ctl, 32'h9);
        chk({31'h0, idle}, 32'h1);
        wr(ctl, 32'h8);
        chk({31'h0, idle}, 32'h0);
    endtask : s_modes
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        pixel_valid <= 1'b1;
        clr <= 1'b0;
        @(posedge mclk);
        wr(stn_pkg::timing_off, 32'h00200C02);
        s_regs;
        s_levels;
        s_lut;
        s_modes;
        test_done;
    end
    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        test_done;
    end
endmodule : stn_color_lut_frc_dither_tb
bind stn_color_lut_frc_dither stn_properties props (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pixel_valid(pixel_valid),
    .pixel_ready(pixel_ready), .pixel_shift_clock(pixel_shift_clock), .pixel_data_out(pixel_data_out),
    .frame_pulse(frame_pulse), .line_pulse(line_pulse), .ac_bias_toggle(ac_bias_toggle),
    .display_only_idle_mode(display_only_idle_mode));
